// file: design/gpdc_pkg.sv
/*
 * Package for the gripper process-data command interpreter: command codes,
 * state-word bit positions, recipe layout and cycle timing.
 * Assumes a 125 MHz clock and a process-data frame from the link logic.
 */
package gpdc_pkg;
   // ----------------------------------------------------------------------
   // Command word codes (one bit each, none for CMD_NONE)
   // ----------------------------------------------------------------------
   localparam logic [15:0] CMD_NONE = 16'h0000;
   localparam logic [15:0] CMD_APPLY_DATA_SET = 16'h0001;
   localparam logic [15:0] CMD_STORE_RECIPE = 16'h0002;
   localparam logic [15:0] CMD_CLEAR_DIRECTION_LATCH = 16'h0004;
   localparam logic [15:0] CMD_CAPTURE_POSITION = 16'h0008;
   localparam logic [15:0] CMD_RECALIBRATE_ENDS = 16'h0080;
   localparam logic [15:0] CMD_GO_OUTER = 16'h0100;
   localparam logic [15:0] CMD_GO_INNER = 16'h0200;
   localparam logic [15:0] CMD_FAULT_ACKNOWLEDGE = 16'h8000;

   // ----------------------------------------------------------------------
   // State word bit positions
   // ----------------------------------------------------------------------
   localparam int SW_AT_OUTER = 0;
   localparam int SW_AT_INNER = 1;
   localparam int SW_FAULT_ACTIVE = 3;
   localparam int SW_IN_WINDOW = 4;
   localparam int SW_CONTROLLER_LINK_ACTIVE = 6;
   localparam int SW_MOVING = 8;
   localparam int SW_TRANSFER_ACKNOWLEDGED = 12;

   // ----------------------------------------------------------------------
   // Recipes, force stages, direction latch, reset values
   // ----------------------------------------------------------------------
   localparam int RECIPE_COUNT = 32;
   localparam int RECIPE_WIDTH = 40;
   localparam logic [7:0] FORCE_MIN = 8'h01;
   localparam logic [7:0] FORCE_MAX = 8'h04;
   localparam logic [7:0] FORCE_RESET = 8'h01;
   localparam logic [1:0] DIR_NONE = 2'h0;
   localparam logic [1:0] DIR_OUTER = 2'h1;
   localparam logic [1:0] DIR_INNER = 2'h2;

   // ----------------------------------------------------------------------
   // Communication cycle timing
   // ----------------------------------------------------------------------
   localparam int CYCLE_TIME_US = 5000;
   localparam int CLK_MHZ = 125;
   localparam int CYCLE_CLKS = CYCLE_TIME_US * CLK_MHZ;

   // Interpreter states
   typedef enum logic [2:0] {
      GPDC_IDLE = 3'h1,
      GPDC_LOAD = 3'h2,
      GPDC_TEACH = 3'h4
   } gpdc_fsm_t;
endpackage

// file: design/gpdc_cycle_tick.sv
/*
 * Divider giving a one-cycle pulse once per communication cycle.
 * Assumes a single clock and synchronous active-low reset.
 */
module gpdc_cycle_tick #(
   parameter int CLKS = gpdc_pkg::CYCLE_CLKS
) (
   input wire logic clk_i,   // System clock
   input wire logic rstn_i,  // Sync reset, active low
   output logic tick_o       // One pulse per cycle
);
   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } gpdc_tick_st_t;

   gpdc_tick_st_t st;
   gpdc_tick_st_t next_st;

   // Count down and pulse at wrap
   always_comb
   begin
      next_st = st;
      next_st.tick = 1'b0;
      if (st.cnt == 32'h0)
      begin
         next_st.cnt = 32'(CLKS - 1);
         next_st.tick = 1'b1;
      end
      else
      begin
         next_st.cnt = st.cnt - 32'h1;
      end
   end

   // State register
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign tick_o = st.tick;
endmodule

// file: design/gpdc_recipe_mem.sv
/*
 * Recipe store: one write port, one read port with registered data.
 * Assumes addresses already range-checked by the caller.
 */
module gpdc_recipe_mem #(
   parameter int DEPTH = gpdc_pkg::RECIPE_COUNT + 1,
   parameter int WIDTH = gpdc_pkg::RECIPE_WIDTH
) (
   input wire logic clk_i,              // System clock
   input wire logic rstn_i,             // Sync reset, active low
   input wire logic wr_en_i,            // Write strobe
   input wire logic [5:0] wr_addr_i,    // Write address
   input wire logic [WIDTH-1:0] wr_data_i, // Write data
   input wire logic rd_en_i,            // Read strobe
   input wire logic [5:0] rd_addr_i,    // Read address
   output logic [WIDTH-1:0] rd_data_o   // Read data, one cycle later
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0] rd;
   } gpdc_mem_st_t;

   gpdc_mem_st_t st;
   gpdc_mem_st_t next_st;

   // Write and registered read
   always_comb
   begin
      next_st = st;
      if (wr_en_i)
      begin
         next_st.mem[wr_addr_i] = wr_data_i;
      end
      if (rd_en_i)
      begin
         next_st.rd = st.mem[rd_addr_i];
      end
   end

   // State register
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign rd_data_o = st.rd;
endmodule

// file: design/gpdc_top.sv
/*
 * Command interpreter for a two-jaw gripper driven by cyclic process data.
 * Assumes the link logic presents each received frame on the process-data
 * inputs on the clk_i domain; end-stop inputs come from pins.
 */
// Notes on behaviour
// - Gripper is fully run by the six cyclic master-to-device fields.
// - Gripper returns state word, fault code and jaw position each cycle.
// - Process data is exchanged once per 5 ms communication cycle.
// - Parameters become active only through the transfer handshake.
// - After a transfer, state-word bit 12 goes true.
// - Command 0x0000 clears bit 12, which completes the transfer.
// - Apply uses cyclic fields for recipe 0, stored recipe for 1..32.
// - Store-recipe writes current cyclic parameters into selected recipe.
// - Clear-direction-latch lets a repeated move to same side run.
// - Capture stores jaw position as recipe's expected position, index nonzero.
// - Recalibrate-ends relearns both end positions when no other bit is set.
// - Bit 8 drives jaws outward, bit 9 drives them inward.
// - Fault acknowledge clears resettable faults; others stay.
// - Losing a gripped part does not stop travel to the end position.
// - Recipe index above zero loads that recipe; valid range 0..32.
// - Position window in 0.01 mm steps, applied both sides of expected.
// - Force level selects stage one to four.
module gpdc_top #(
   parameter int CYCLE_CLKS = gpdc_pkg::CYCLE_CLKS
) (
   input wire logic clk_i,                      // System clock, 125 MHz
   input wire logic rstn_i,                     // Sync reset, active low
   input wire logic frame_valid_i,              // Link frame present
   input wire logic [15:0] command_word_i,      // Command word
   input wire logic [7:0] profile_select_i,     // Gripping profile
   input wire logic [7:0] recipe_index_i,       // Recipe number
   input wire logic [15:0] expected_part_position_i, // Expected part position
   input wire logic [7:0] force_level_i,        // Force stage
   input wire logic [7:0] position_window_i,    // Window, 0.01 mm
   input wire logic [15:0] jaw_position_i,      // Measured jaw position
   input wire logic at_outer_i,                 // Outer end-stop pin
   input wire logic at_inner_i,                 // Inner end-stop pin
   input wire logic fault_set_i,                // Fault event pulse
   input wire logic [15:0] fault_code_i,        // Code of that fault
   input wire logic fault_resettable_i,         // That fault may be acked
   output logic [15:0] state_word_o,            // State word
   output logic [15:0] fault_code_o,            // Active fault code
   output logic [15:0] jaw_position_now_o,      // Jaw position
   output logic [7:0] active_profile_o,         // Active profile
   output logic [15:0] active_expected_o,       // Active expected position
   output logic [7:0] active_force_o,           // Active force stage
   output logic [7:0] active_window_o,          // Active window
   output logic drive_outer_o,                  // Drive jaws outward
   output logic drive_inner_o,                  // Drive jaws inward
   output logic recalibrate_o                   // Relearn ends, one pulse
);
   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      gpdc_pkg::gpdc_fsm_t fsm;
      logic [15:0] cmd_prev;
      logic [5:0] rec_idx;
      logic xfer_ack;
      logic [7:0] act_profile;
      logic [15:0] act_expected;
      logic [7:0] act_force;
      logic [7:0] act_window;
      logic [1:0] dir_latch;
      logic drive_outer;
      logic drive_inner;
      logic recal;
      logic [15:0] fault;
      logic fault_res;
      logic [1:0] sync_outer;
      logic [1:0] sync_inner;
      logic link_active;
      logic [15:0] jaw_pos;
      logic [15:0] state_word;
   } gpdc_top_st_t;

   gpdc_top_st_t st;
   gpdc_top_st_t next_st;
   logic tick;
   logic mem_wr;
   logic mem_rd;
   logic [5:0] mem_addr;
   logic [gpdc_pkg::RECIPE_WIDTH-1:0] mem_wdata;
   logic [gpdc_pkg::RECIPE_WIDTH-1:0] mem_rdata;
   logic cmd_valid;
   logic cmd_new;
   logic idx_ok;
   logic idx_zero;
   logic [16:0] lo_bound;
   logic [16:0] hi_bound;

   // ----------------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------------
   gpdc_cycle_tick #(.CLKS(CYCLE_CLKS)) u_tick (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .tick_o(tick)
   );

   gpdc_recipe_mem u_mem (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .wr_en_i(mem_wr),
      .wr_addr_i(mem_addr),
      .wr_data_i(mem_wdata),
      .rd_en_i(mem_rd),
      .rd_addr_i(mem_addr),
      .rd_data_o(mem_rdata)
   );

   // Command qualification: only zero and the defined single-bit codes act
   always_comb
   begin
      case (command_word_i)
         gpdc_pkg::CMD_NONE,
         gpdc_pkg::CMD_APPLY_DATA_SET,
         gpdc_pkg::CMD_STORE_RECIPE,
         gpdc_pkg::CMD_CLEAR_DIRECTION_LATCH,
         gpdc_pkg::CMD_CAPTURE_POSITION,
         gpdc_pkg::CMD_RECALIBRATE_ENDS,
         gpdc_pkg::CMD_GO_OUTER,
         gpdc_pkg::CMD_GO_INNER,
         gpdc_pkg::CMD_FAULT_ACKNOWLEDGE: cmd_valid = 1'b1;
         default: cmd_valid = 1'b0;
      endcase
   end

   // Frames are sampled once per communication cycle
   assign cmd_new = tick && frame_valid_i && cmd_valid
                    && (command_word_i != st.cmd_prev);
   assign idx_zero = (recipe_index_i == 8'h00);
   assign idx_ok = !idx_zero
                   && (recipe_index_i <= 8'(gpdc_pkg::RECIPE_COUNT));
   assign mem_addr = (st.fsm == gpdc_pkg::GPDC_TEACH) ? st.rec_idx : recipe_index_i[5:0];

   // Window symmetric about expected position
   assign lo_bound = ({8'h00, st.act_window} > st.act_expected) ? 17'h00000
                     : {1'b0, st.act_expected} - {9'h0, st.act_window};
   assign hi_bound = {1'b0, st.act_expected} + {9'h0, st.act_window};

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      mem_wr = 1'b0;
      mem_rd = 1'b0;
      mem_wdata = {profile_select_i, expected_part_position_i,
                   force_level_i, position_window_i};
      next_st.recal = 1'b0;
      next_st.sync_outer = {st.sync_outer[0], at_outer_i};
      next_st.sync_inner = {st.sync_inner[0], at_inner_i};
      next_st.link_active = frame_valid_i;
      next_st.jaw_pos = jaw_position_i;
      if (tick && frame_valid_i && cmd_valid)
      begin
         next_st.cmd_prev = command_word_i;
      end
      case (st.fsm)
         gpdc_pkg::GPDC_IDLE:
         begin
            if (cmd_new)
            begin
               case (command_word_i)
                  gpdc_pkg::CMD_NONE:
                  begin
                     next_st.xfer_ack = 1'b0;
                  end
                  gpdc_pkg::CMD_APPLY_DATA_SET:
                  begin
                     if (idx_zero)
                     begin
                        next_st.act_profile = profile_select_i;
                        next_st.act_expected = expected_part_position_i;
                        if (force_level_i >= gpdc_pkg::FORCE_MIN
                            && force_level_i <= gpdc_pkg::FORCE_MAX)
                        begin
                           next_st.act_force = force_level_i;
                        end
                        next_st.act_window = position_window_i;
                        next_st.xfer_ack = 1'b1;
                     end
                     else if (idx_ok)
                     begin
                        mem_rd = 1'b1;
                        next_st.fsm = gpdc_pkg::GPDC_LOAD;
                     end
                  end
                  gpdc_pkg::CMD_STORE_RECIPE:
                  begin
                     mem_wr = idx_ok;
                  end
                  gpdc_pkg::CMD_CLEAR_DIRECTION_LATCH:
                  begin
                     next_st.dir_latch = gpdc_pkg::DIR_NONE;
                  end
                  gpdc_pkg::CMD_CAPTURE_POSITION:
                  begin
                     if (idx_ok)
                     begin
                        mem_rd = 1'b1;
                        next_st.rec_idx = recipe_index_i[5:0];
                        next_st.fsm = gpdc_pkg::GPDC_TEACH;
                     end
                  end
                  gpdc_pkg::CMD_RECALIBRATE_ENDS:
                  begin
                     next_st.recal = 1'b1;
                     next_st.drive_outer = 1'b0;
                     next_st.drive_inner = 1'b0;
                  end
                  gpdc_pkg::CMD_GO_OUTER:
                  begin
                     if (st.dir_latch != gpdc_pkg::DIR_OUTER)
                     begin
                        next_st.drive_outer = 1'b1;
                        next_st.drive_inner = 1'b0;
                        next_st.dir_latch = gpdc_pkg::DIR_OUTER;
                     end
                  end
                  gpdc_pkg::CMD_GO_INNER:
                  begin
                     if (st.dir_latch != gpdc_pkg::DIR_INNER)
                     begin
                        next_st.drive_inner = 1'b1;
                        next_st.drive_outer = 1'b0;
                        next_st.dir_latch = gpdc_pkg::DIR_INNER;
                     end
                  end
                  gpdc_pkg::CMD_FAULT_ACKNOWLEDGE:
                  begin
                     if (st.fault_res)
                     begin
                        next_st.fault = 16'h0000;
                        next_st.fault_res = 1'b0;
                     end
                  end
                  default:
                  begin
                     next_st.fsm = gpdc_pkg::GPDC_IDLE;
                  end
               endcase
            end
         end
         gpdc_pkg::GPDC_LOAD:
         begin
            // Stored recipe becomes the active set
            {next_st.act_profile, next_st.act_expected} = mem_rdata[39:16];
            if (mem_rdata[15:8] >= gpdc_pkg::FORCE_MIN
                && mem_rdata[15:8] <= gpdc_pkg::FORCE_MAX)
            begin
               next_st.act_force = mem_rdata[15:8];
            end
            next_st.act_window = mem_rdata[7:0];
            next_st.xfer_ack = 1'b1;
            next_st.fsm = gpdc_pkg::GPDC_IDLE;
         end
         gpdc_pkg::GPDC_TEACH:
         begin
            // Replace the expected position of the read record
            mem_wr = 1'b1;
            mem_wdata = {mem_rdata[39:32], st.jaw_pos, mem_rdata[15:0]};
            next_st.fsm = gpdc_pkg::GPDC_IDLE;
         end
         default:
         begin
            next_st.fsm = gpdc_pkg::GPDC_IDLE;
         end
      endcase
      // Travel ends at an end stop, on recalibrate or on a reverse move, not on part loss
      if (st.drive_outer && st.sync_outer[1])
      begin
         next_st.drive_outer = 1'b0;
      end
      if (st.drive_inner && st.sync_inner[1])
      begin
         next_st.drive_inner = 1'b0;
      end
      // A new fault wins over an acknowledge
      if (fault_set_i)
      begin
         next_st.fault = fault_code_i;
         next_st.fault_res = fault_resettable_i;
      end
      // Returned state word
      next_st.state_word = 16'h0000;
      next_st.state_word[gpdc_pkg::SW_AT_OUTER] = st.sync_outer[1];
      next_st.state_word[gpdc_pkg::SW_AT_INNER] = st.sync_inner[1];
      next_st.state_word[gpdc_pkg::SW_FAULT_ACTIVE] = (st.fault != 16'h0000);
      next_st.state_word[gpdc_pkg::SW_IN_WINDOW] =
         ({1'b0, st.jaw_pos} >= lo_bound) && ({1'b0, st.jaw_pos} <= hi_bound);
      next_st.state_word[gpdc_pkg::SW_CONTROLLER_LINK_ACTIVE] = st.link_active;
      next_st.state_word[gpdc_pkg::SW_MOVING] = st.drive_outer || st.drive_inner;
      next_st.state_word[gpdc_pkg::SW_TRANSFER_ACKNOWLEDGED] = st.xfer_ack;
   end

   // State register
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         st <= '0;
         st.fsm <= gpdc_pkg::GPDC_IDLE;
         st.act_force <= gpdc_pkg::FORCE_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs straight from flip-flops
   assign state_word_o = st.state_word;
   assign fault_code_o = st.fault;
   assign jaw_position_now_o = st.jaw_pos;
   assign active_profile_o = st.act_profile;
   assign active_expected_o = st.act_expected;
   assign active_force_o = st.act_force;
   assign active_window_o = st.act_window;
   assign drive_outer_o = st.drive_outer;
   assign drive_inner_o = st.drive_inner;
   assign recalibrate_o = st.recal;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   chk_ack_clear_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cmd_new && command_word_i == 16'h0000 && st.fsm == gpdc_pkg::GPDC_IDLE
      |=> !st.xfer_ack ##1 !state_word_o[12])
      else $error("transfer ack not cleared");
   chk_apply_cyclic: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cmd_new && command_word_i == 16'h0001 && idx_zero && st.fsm == gpdc_pkg::GPDC_IDLE
      |=> st.xfer_ack && st.act_window == $past(position_window_i)
          ##1 state_word_o[12])
      else $error("cyclic set not applied");
   chk_recipe_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cmd_new && command_word_i == 16'h0001 && idx_ok && st.fsm == gpdc_pkg::GPDC_IDLE
      |=> st.fsm == gpdc_pkg::GPDC_LOAD ##1 st.xfer_ack)
      else $error("recipe not loaded in two cycles");
   chk_no_bad_cmd: assert property (@(posedge clk_i) disable iff (!rstn_i)
      tick && !cmd_valid && st.fsm == gpdc_pkg::GPDC_IDLE
      |=> !st.recal && $stable(st.dir_latch) && $stable(st.xfer_ack))
      else $error("invalid command acted on");
   chk_recal_pulse: assert property (@(posedge clk_i) disable iff (!rstn_i)
      recalibrate_o |=> !recalibrate_o && !drive_outer_o && !drive_inner_o)
      else $error("recalibrate not a single pulse");
   chk_drive_exclusive: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !(drive_outer_o && drive_inner_o))
      else $error("both directions driven");
   chk_fault_keep: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cmd_new && command_word_i == 16'h8000 && !st.fault_res && !fault_set_i
      |=> $stable(fault_code_o))
      else $error("non-resettable fault cleared");
   chk_params_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $changed(active_force_o) || $changed(active_window_o) |-> st.xfer_ack)
      else $error("parameters changed without handshake");
   chk_direction_latch: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cmd_new && command_word_i == gpdc_pkg::CMD_GO_INNER
      && st.dir_latch == gpdc_pkg::DIR_INNER && st.fsm == gpdc_pkg::GPDC_IDLE
      |=> !$rose(drive_inner_o))
      else $error("latched move repeated");
endmodule

// file: verif/gpdc_master_model.sv
/* Process-data master model: presents one cyclic frame per send call.
   Assumes the interpreter samples its inputs on a tick every CLKS clocks. */
module gpdc_master_model #(
   parameter int CLKS = 16
) (
   input wire logic clk_i,       // System clock
   output logic frame_valid_o,   // Frame present
   output logic [15:0] cmd_o,    // Command word
   output logic [7:0] prof_o,    // Profile select
   output logic [7:0] idx_o,     // Recipe index
   output logic [15:0] pos_o,    // Expected part position
   output logic [7:0] force_o,   // Force stage
   output logic [7:0] win_o      // Position window
);
   timeunit 1ns;
   timeprecision 1ps;
   // Quiet link until the first frame
   initial
   begin
      frame_valid_o = 1'b0;
      {cmd_o, prof_o, idx_o, pos_o, force_o, win_o} = '0;
   end
   // One frame held over a full tick period, record is {profile, position, force, window}
   task automatic send(input logic [15:0] c, input logic [7:0] i, input logic [39:0] r);
      @(negedge clk_i);
      frame_valid_o = 1'b1;
      cmd_o = c;
      idx_o = i;
      {prof_o, pos_o, force_o, win_o} = r;
      repeat (CLKS + 3) @(negedge clk_i);
   endtask
endmodule

// file: verif/testbench.sv
/* Self-checking bench for the gripper command interpreter.
   Assumes gpdc_top with a short cycle tick and the master model beside it. */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CLKS = 16;
   logic clk_i, rstn_i, frame_valid_i, at_outer_i, at_inner_i, fault_set_i, fault_resettable_i;
   logic drive_outer_o, drive_inner_o, recalibrate_o;
   logic [15:0] command_word_i, expected_part_position_i, jaw_position_i, fault_code_i;
   logic [15:0] state_word_o, fault_code_o, jaw_position_now_o, active_expected_o;
   logic [7:0] profile_select_i, recipe_index_i, force_level_i, position_window_i;
   logic [7:0] active_profile_o, active_force_o, active_window_o;
   logic [39:0] act, rec5, r, recal_n = '0;
   logic [31:0] seed = 32'h49;
   logic [23:0] bad [5] = '{24'h000300, 24'h004000, 24'h800100, 24'h000121, 24'h008100};
   int err_total = 0;
   int checks = 0;
   wire logic [39:0] cur = {active_profile_o, active_expected_o, active_force_o, active_window_o};
   gpdc_top #(.CYCLE_CLKS(CLKS)) gpdc_top_i (.clk_i, .rstn_i, .frame_valid_i, .command_word_i,
      .profile_select_i, .recipe_index_i, .expected_part_position_i, .force_level_i,
      .position_window_i, .jaw_position_i, .at_outer_i, .at_inner_i, .fault_set_i,
      .fault_code_i, .fault_resettable_i, .state_word_o, .fault_code_o, .jaw_position_now_o,
      .active_profile_o, .active_expected_o, .active_force_o, .active_window_o,
      .drive_outer_o, .drive_inner_o, .recalibrate_o);
   gpdc_master_model #(.CLKS(CLKS)) gpdc_master_model_i (.clk_i, .frame_valid_o(frame_valid_i),
      .cmd_o(command_word_i), .prof_o(profile_select_i), .idx_o(recipe_index_i),
      .pos_o(expected_part_position_i), .force_o(force_level_i), .win_o(position_window_i));
   // Xorshift record source, force kept in 1..4
   function automatic logic [39:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return {seed[31:8], {6'h00, seed[1:0]} + 8'h01, seed[9:2]};
   endfunction
   // Active set after cyclic fields are taken over
   function automatic logic [39:0] taken(input logic [39:0] old, input logic [39:0] cyc);
      taken = cyc;
      if (cyc[15:8] == 8'h00 || cyc[15:8] > 8'h04)
         taken[15:8] = old[15:8];
   endfunction
   // Jaw inside the window on either side of the expected position
   function automatic logic inwin(input logic [15:0] j, input logic [39:0] a);
      return ((j > a[31:16]) ? j - a[31:16] : a[31:16] - j) <= {8'h00, a[7:0]};
   endfunction
   // Compare and count
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tx(input logic [15:0] c, input logic [7:0] i, input logic [39:0] d);
      gpdc_master_model_i.send(c, i, d);
   endtask
   // End stop reached, drive must drop
   task automatic hit(input logic [1:0] s);
      {at_outer_i, at_inner_i} = s;
      repeat (5) @(negedge clk_i);
      chk({37'h0, drive_outer_o, drive_inner_o, state_word_o[8]}, 40'h0);
      chk({38'h0, state_word_o[0], state_word_o[1]}, {38'h0, s});
      {at_outer_i, at_inner_i} = 2'h0;
   endtask
   // Fault event pulse
   task automatic flt(input logic [15:0] c, input logic res);
      @(negedge clk_i);
      {fault_set_i, fault_code_i, fault_resettable_i} = {1'b1, c, res};
      @(negedge clk_i);
      fault_set_i = 1'b0;
      repeat (3) @(negedge clk_i);
   endtask
   task automatic summarize();
      if (err_total == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Clock, recalibrate pulse count, watchdog
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(negedge clk_i)
      if (recalibrate_o === 1'b1)
         recal_n++;
   initial
   begin
      #50000;
      err_total++;
      summarize();
   end
   // Main sequence
   initial
   begin
      rstn_i = 1'b0;
      {at_outer_i, at_inner_i, fault_set_i, fault_resettable_i, fault_code_i} = '0;
      jaw_position_i = 16'h0123;
      act = 40'h0000000100;
      repeat (2) @(negedge clk_i);
      rstn_i = 1'b1;
      chk(cur, act);
      chk({state_word_o, drive_outer_o, drive_inner_o, recalibrate_o}, 40'h0);
      for (int k = 0; k < 4; k++)
      begin
         r = rnd();
         tx(16'h0001, 8'h00, r);
         act = taken(act, r);
         chk(cur, act);
         chk({36'h0, state_word_o[14], state_word_o[12], state_word_o[6], state_word_o[4]},
             {36'h0, 3'h3, inwin(16'h0123, act)});
         chk({24'h0, jaw_position_now_o}, 40'h123);
         tx(16'h0000, 8'h00, rnd());
         chk({cur[39:1], state_word_o[12]}, {act[39:1], 1'b0});
      end
      rec5 = rnd();
      tx(16'h0002, 8'h05, rec5);
      tx(16'h0000, 8'h05, rnd());
      tx(16'h0001, 8'h05, rnd());
      chk(cur, rec5);
      tx(16'h0000, 8'h05, rnd());
      jaw_position_i = 16'h0456;
      tx(16'h0008, 8'h05, rnd());
      tx(16'h0000, 8'h05, rnd());
      tx(16'h0001, 8'h05, rnd());
      act = {rec5[39:32], 16'h0456, rec5[15:0]};
      chk(cur, act);
      chk({39'h0, state_word_o[4]}, {39'h0, inwin(16'h0456, act)});
      tx(16'h0000, 8'h05, rnd());
      for (int k = 0; k < 5; k++)
      begin
         tx(bad[k][23:8], bad[k][7:0], rnd());
         chk({cur[39:1], state_word_o[12]}, {act[39:1], 1'b0});
      end
      tx(16'h0000, 8'h00, rnd());
      r = rnd();
      r[15:8] = 8'h05;
      tx(16'h0001, 8'h00, r);
      act = taken(act, r);
      chk(cur, act);
      tx(16'h0000, 8'h00, r);
      tx(16'h0080, 8'h00, r);
      chk(recal_n, 40'h1);
      tx(16'h0100, 8'h00, r);
      chk({37'h0, drive_outer_o, drive_inner_o, state_word_o[8]}, 40'h5);
      hit(2'h2);
      tx(16'h0200, 8'h00, r);
      chk({38'h0, drive_outer_o, drive_inner_o}, 40'h1);
      hit(2'h1);
      tx(16'h0000, 8'h00, r);
      tx(16'h0200, 8'h00, r);
      chk({38'h0, drive_outer_o, drive_inner_o}, 40'h0);
      tx(16'h0004, 8'h00, r);
      tx(16'h0200, 8'h00, r);
      chk({38'h0, drive_outer_o, drive_inner_o}, 40'h1);
      hit(2'h1);
      flt(16'h00a5, 1'b1);
      chk({fault_code_o, state_word_o[3]}, 40'h14b);
      tx(16'h8000, 8'h00, r);
      chk({24'h0, fault_code_o}, 40'h0);
      tx(16'h0000, 8'h00, r);
      flt(16'h005a, 1'b0);
      tx(16'h8000, 8'h00, r);
      chk({24'h0, fault_code_o}, 40'h5a);
      summarize();
   end
endmodule
